// ==== hw/dsof_pkg.sv ====
// Constants, register map and state types for the drive status output flags.
// Assumes a single 125 MHz control clock and a 1 ms system tick.
`default_nettype none
package dsof_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES_DEF = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_MS = TICK_US / 1000;
  // Start-up relay delay must stay under 2 s
  localparam int unsigned PWRUP_MS = 1500;
  localparam logic [10:0] PWRUP_TICKS = 11'(PWRUP_MS / TICK_MS);
  localparam int unsigned ALARM_MS = 300;
  localparam logic [8:0] ALARM_TICKS = 9'(ALARM_MS / TICK_MS);
  // On/off delays are set in 0.1 s steps, 0.0 to 100.0 s
  localparam int unsigned DLY_STEP_MS = 100;
  localparam logic [16:0] DLY_STEP_TICKS = 17'(DLY_STEP_MS / TICK_MS);
  localparam logic [9:0] DLY_MAX = 10'h03E8;
  // ************************************************************
  // Function codes and reset values
  // ************************************************************
  localparam logic [7:0] FN_OVERLOAD = 8'h03;
  localparam logic [7:0] FN_DEVIATION = 8'h04;
  localparam logic [7:0] FN_ALARM = 8'h05;
  localparam logic [7:0] T11_CODE_RST = 8'h05;
  localparam logic [7:0] RLY_CODE_RST = 8'h05;
  localparam logic SENSE_NC_RST = 1'b1;
  localparam logic [7:0] OL_THR_RST = 8'h64;
  localparam logic [7:0] DEV_THR_RST = 8'h03;
  localparam logic [9:0] DLY_RST = 10'h000;
  // ************************************************************
  // Register map (byte offsets) and field positions
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OL_THR = 8'h04;
  localparam logic [7:0] REG_DEV_THR = 8'h08;
  localparam logic [7:0] REG_T11_DLY = 8'h0C;
  localparam logic [7:0] REG_RLY_DLY = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_MASK = 8'h18;
  localparam logic [7:0] REG_STATE = 8'h1C;
  localparam int CTRL_T11_LSB = 0;
  localparam int CTRL_RLY_LSB = 8;
  localparam int CTRL_SENSE_BIT = 16;
  localparam int DLY_ON_LSB = 0;
  localparam int DLY_OFF_LSB = 16;
  localparam int EV_OL_BIT = 0;
  localparam int EV_OD_BIT = 1;
  localparam int EV_AL_BIT = 2;
  localparam int ST_POWERED_BIT = 3;
  localparam int ST_COIL_BIT = 4;
  // ************************************************************
  // State types
  // ************************************************************
  typedef struct packed {
    logic [7:0] t11_code;
    logic [7:0] rly_code;
    logic sense_nc;
    logic [7:0] ol_thr;
    logic [7:0] dev_thr;
    logic [9:0] t11_on;
    logic [9:0] t11_off;
    logic [9:0] rly_on;
    logic [9:0] rly_off;
    logic [2:0] status;
    logic [2:0] mask;
    logic [16:0] tick_cnt;
    logic tick;
    logic [10:0] pwr_cnt;
    logic powered;
    logic [8:0] al_cnt;
    logic ol;
    logic od;
    logic al;
    logic t11_n;
    logic coil;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
  } dsof_state_s;
  typedef struct packed {
    logic [16:0] cnt;
    logic level;
  } dsof_dly_s;
endpackage
`default_nettype wire

// ==== hw/dsof_delay_if.sv ====
// Carrier between the flag logic and one on/off delay stage.
// Assumes the owner drives input level, both delays and the tick enable.
`default_nettype none
interface dsof_delay_if;
  logic in_level;
  logic [9:0] on_dly;
  logic [9:0] off_dly;
  logic tick;
  logic out_level;
  modport stage (input in_level, input on_dly, input off_dly, input tick, output out_level);
  modport owner (output in_level, output on_dly, output off_dly, output tick, input out_level);
endinterface
`default_nettype wire

// ==== hw/dsof_onoff_delay.sv ====
// One programmable turn-on/turn-off delay stage of an output terminal.
// Assumes a one-cycle tick enable every millisecond.
`default_nettype none
module dsof_onoff_delay
  import dsof_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  dsof_delay_if.stage dly
);
  import dsof_pkg::*;

  dsof_dly_s r;
  dsof_dly_s next_r;
  logic [9:0] sel;
  logic [16:0] limit;

  always_comb begin
    next_r = r;
    sel = dly.in_level ? dly.on_dly : dly.off_dly;
    if (sel > DLY_MAX) begin
      sel = DLY_MAX;
    end
    limit = 17'(sel * DLY_STEP_TICKS);
    if (dly.in_level == r.level) begin
      next_r.cnt = '0;
    end else if (limit == '0) begin
      next_r.level = dly.in_level;
    end else if (dly.tick) begin
      // A pulse shorter than the delay restarts the count and never shows
      if (r.cnt + 17'h0_0001 >= limit) begin
        next_r.level = dly.in_level;
        next_r.cnt = '0;
      end else begin
        next_r.cnt = r.cnt + 17'h0_0001;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign dly.out_level = r.level;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  a_dly_no_early: assert property (
    (r.level != $past(r.level)) |-> ($past(limit) == '0 || $past(dly.tick)))
    else $error("delay stage switched without tick");
endmodule
`default_nettype wire

// ==== hw/dsof_status_flags.sv ====
// Drive status output flags: overload, loop deviation and trip alarm,
// routed to the transistor terminal and the changeover relay coil.
// Assumes synchronous inputs in percent and an Avalon-MM master with waitrequest.
//
// Behaviour
// - With code 03 an output is active while current is above the overload threshold, off below.
// - The overload threshold is a software setting in percent, 100 after reset.
// - Overload comparison runs regardless of motoring or regenerative braking.
// - The transistor terminal is active low, pulled to ground when asserted.
// - Loop error is the magnitude of setpoint minus process value.
// - With code 04 the output is active while loop error exceeds the deviation threshold.
// - The deviation threshold is a software setting in percent, 3 after reset.
// - With code 05 the alarm is active from a trip until it is cleared.
// - The alarm can be routed to the transistor terminal or to the relay.
// - Relay contact sense resets to normally closed, value 1.
// - Normally closed, the relay energizes after a start-up delay under 2 s.
// - Normally closed, a trip or power loss leaves the relay de-energized.
// - Normally open, value 0, the relay energizes only while a trip is present.
// - The alarm follows the internal fault with a 300 ms delay.
// - Each terminal passes through on and off delays of 0.0 to 100.0 s.
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`default_nettype none
module dsof_status_flags
  import dsof_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [7:0] current_pct_in,
  input wire logic [7:0] setpoint_pct_in,
  input wire logic [7:0] feedback_pct_in,
  input wire logic fault_trip_in,
  output logic overload_warning_out,
  output logic loop_deviation_out,
  output logic trip_alarm_out,
  output logic term11_n_out,
  output logic relay_coil_out,
  output logic irq_out
);
  import dsof_pkg::*;

  // ************************************************************
  // State and delay stages
  // ************************************************************
  dsof_state_s r;
  dsof_state_s next_r;
  dsof_delay_if t11_if ();
  dsof_delay_if rly_if ();

  dsof_onoff_delay u_t11_dly (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .dly(t11_if.stage)
  );

  dsof_onoff_delay u_rly_dly (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .dly(rly_if.stage)
  );

  function automatic logic pick(input logic [7:0] code, input dsof_state_s s);
    logic v;
    v = 1'b0;
    case (code)
      FN_OVERLOAD: v = s.ol;
      FN_DEVIATION: v = s.od;
      FN_ALARM: v = s.al;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  assign t11_if.in_level = pick(r.t11_code, r);
  assign t11_if.on_dly = r.t11_on;
  assign t11_if.off_dly = r.t11_off;
  assign t11_if.tick = r.tick;
  assign rly_if.in_level = pick(r.rly_code, r);
  assign rly_if.on_dly = r.rly_on;
  assign rly_if.off_dly = r.rly_off;
  assign rly_if.tick = r.tick;

  logic [8:0] err_diff;
  logic [7:0] err_mag;
  logic req;
  logic done;
  logic [31:0] ctrl_word;
  logic [31:0] rd;
  logic [31:0] wv;
  logic [2:0] events;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    next_r = r;
    rd = '0;
    wv = '0;
    req = avs_read_in || avs_write_in;
    done = req && !r.waitreq;
    err_diff = {1'b0, setpoint_pct_in} - {1'b0, feedback_pct_in};
    err_mag = err_diff[8] ? 8'(-err_diff) : err_diff[7:0];
    ctrl_word = '0;
    ctrl_word[CTRL_T11_LSB +: 8] = r.t11_code;
    ctrl_word[CTRL_RLY_LSB +: 8] = r.rly_code;
    ctrl_word[CTRL_SENSE_BIT] = r.sense_nc;

    // Fixed 1 ms tick for every timer
    next_r.tick = 1'b0;
    if (r.tick_cnt >= 17'(TICK_CYCLES - 1)) begin
      next_r.tick_cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 17'h0_0001;
    end

    // No motoring or braking input gates this compare
    if (current_pct_in > r.ol_thr) begin
      next_r.ol = 1'b1;
    end else if (current_pct_in < r.ol_thr) begin
      next_r.ol = 1'b0;
    end
    if (err_mag > r.dev_thr) begin
      next_r.od = 1'b1;
    end else if (err_mag < r.dev_thr) begin
      next_r.od = 1'b0;
    end

    // Alarm follows the trip level only after it has been stable 300 ms
    if (fault_trip_in == r.al) begin
      next_r.al_cnt = '0;
    end else if (r.tick) begin
      if (r.al_cnt == ALARM_TICKS - 9'h001) begin
        next_r.al = fault_trip_in;
        next_r.al_cnt = '0;
      end else begin
        next_r.al_cnt = r.al_cnt + 9'h001;
      end
    end

    if (!r.powered && r.tick) begin
      if (r.pwr_cnt == PWRUP_TICKS - 11'h001) begin
        next_r.powered = 1'b1;
      end else begin
        next_r.pwr_cnt = r.pwr_cnt + 11'h001;
      end
    end

    next_r.t11_n = !t11_if.out_level;
    if (!r.powered) begin
      next_r.coil = 1'b0;
    end else if (r.sense_nc) begin
      next_r.coil = !rly_if.out_level;
    end else begin
      next_r.coil = rly_if.out_level;
    end

    // ************************************************************
    // Register bus: one wait cycle, then the access completes
    // ************************************************************
    if (avs_address_in == REG_CTRL) begin
      rd = ctrl_word;
    end else if (avs_address_in == REG_OL_THR) begin
      rd = {24'h00_0000, r.ol_thr};
    end else if (avs_address_in == REG_DEV_THR) begin
      rd = {24'h00_0000, r.dev_thr};
    end else if (avs_address_in == REG_T11_DLY) begin
      rd[DLY_ON_LSB +: 10] = r.t11_on;
      rd[DLY_OFF_LSB +: 10] = r.t11_off;
    end else if (avs_address_in == REG_RLY_DLY) begin
      rd[DLY_ON_LSB +: 10] = r.rly_on;
      rd[DLY_OFF_LSB +: 10] = r.rly_off;
    end else if (avs_address_in == REG_STATUS) begin
      rd = {29'h0000_0000, r.status};
    end else if (avs_address_in == REG_MASK) begin
      rd = {29'h0000_0000, r.mask};
    end else if (avs_address_in == REG_STATE) begin
      rd[EV_OL_BIT] = r.ol;
      rd[EV_OD_BIT] = r.od;
      rd[EV_AL_BIT] = r.al;
      rd[ST_POWERED_BIT] = r.powered;
      rd[ST_COIL_BIT] = r.coil;
    end
    wv = merge(rd, avs_writedata_in, avs_byteenable_in);

    if (req && r.waitreq) begin
      next_r.waitreq = 1'b0;
      next_r.rdata = avs_read_in ? rd : '0;
    end else if (!r.waitreq) begin
      next_r.waitreq = 1'b1;
    end

    events = '0;
    events[EV_OL_BIT] = next_r.ol && !r.ol;
    events[EV_OD_BIT] = next_r.od && !r.od;
    events[EV_AL_BIT] = next_r.al && !r.al;
    if (done && avs_read_in && avs_address_in == REG_STATUS) begin
      // Only bits that the read returned are cleared, so a late event is kept
      next_r.status = r.status & ~r.rdata[2:0];
    end
    // An event in the clearing cycle survives the read
    next_r.status = next_r.status | events;

    if (done && avs_write_in) begin
      if (avs_address_in == REG_CTRL) begin
        next_r.t11_code = wv[CTRL_T11_LSB +: 8];
        next_r.rly_code = wv[CTRL_RLY_LSB +: 8];
        next_r.sense_nc = wv[CTRL_SENSE_BIT];
      end else if (avs_address_in == REG_OL_THR) begin
        next_r.ol_thr = wv[7:0];
      end else if (avs_address_in == REG_DEV_THR) begin
        next_r.dev_thr = wv[7:0];
      end else if (avs_address_in == REG_T11_DLY) begin
        next_r.t11_on = wv[DLY_ON_LSB +: 10];
        next_r.t11_off = wv[DLY_OFF_LSB +: 10];
      end else if (avs_address_in == REG_RLY_DLY) begin
        next_r.rly_on = wv[DLY_ON_LSB +: 10];
        next_r.rly_off = wv[DLY_OFF_LSB +: 10];
      end else if (avs_address_in == REG_MASK) begin
        next_r.mask = wv[2:0];
      end
    end
    next_r.irq = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      r <= '0;
      r.t11_code <= T11_CODE_RST;
      r.rly_code <= RLY_CODE_RST;
      r.sense_nc <= SENSE_NC_RST;
      r.ol_thr <= OL_THR_RST;
      r.dev_thr <= DEV_THR_RST;
      r.t11_on <= DLY_RST;
      r.t11_off <= DLY_RST;
      r.rly_on <= DLY_RST;
      r.rly_off <= DLY_RST;
      r.t11_n <= 1'b1;
      r.waitreq <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata_out = r.rdata;
  assign avs_waitrequest_out = r.waitreq;
  assign overload_warning_out = r.ol;
  assign loop_deviation_out = r.od;
  assign trip_alarm_out = r.al;
  assign term11_n_out = r.t11_n;
  assign relay_coil_out = r.coil;
  assign irq_out = r.irq;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  a_ol_sets_above: assert property ((current_pct_in > r.ol_thr) |=> overload_warning_out)
    else $error("overload flag not set above threshold");
  a_ol_clears_below: assert property ((current_pct_in < r.ol_thr) |=> !overload_warning_out)
    else $error("overload flag not cleared below threshold");
  a_dev_sets_above: assert property ((err_mag > r.dev_thr) |=> loop_deviation_out)
    else $error("deviation flag not set above threshold");
  a_dev_magnitude: assert property (
    (setpoint_pct_in < feedback_pct_in) |-> (err_mag == feedback_pct_in - setpoint_pct_in))
    else $error("loop error magnitude wrong");
  a_term_active_low: assert property (
    (r.t11_code == FN_OVERLOAD && r.t11_on == '0 && r.t11_off == '0 && r.ol) [*3]
    |-> !term11_n_out)
    else $error("terminal not pulled low for active overload");
  a_alarm_waits: assert property (
    (trip_alarm_out != $past(trip_alarm_out))
    |-> ($past(r.al_cnt) == ALARM_TICKS - 9'h001 && $past(r.tick)))
    else $error("alarm changed before its delay");
  a_alarm_holds_trip: assert property ((trip_alarm_out && fault_trip_in) |=> trip_alarm_out)
    else $error("alarm dropped while trip present");
  a_coil_pre_power: assert property (!r.powered |=> !relay_coil_out)
    else $error("relay energized before start-up delay");
  a_power_delay: assert property ($rose(r.powered) |-> $past(r.pwr_cnt) == PWRUP_TICKS - 11'h001)
    else $error("start-up delay length wrong");
  a_nc_coil: assert property (
    (r.powered && r.sense_nc && rly_if.out_level) |=> !relay_coil_out)
    else $error("normally closed relay held on during alarm");
  a_no_coil: assert property (
    (r.powered && !r.sense_nc && !rly_if.out_level) |=> !relay_coil_out)
    else $error("normally open relay on without alarm");
  a_irq_level: assert property (irq_out == |(r.status & r.mask))
    else $error("interrupt output disagrees with masked status");
  a_dev_clears_below: assert property ((err_mag < r.dev_thr) |=> !loop_deviation_out)
    else $error("deviation flag not cleared below threshold");
  a_ol_equal_holds: assert property (
    (current_pct_in == r.ol_thr) |=> $stable(overload_warning_out))
    else $error("overload flag moved at threshold");
  a_nc_coil_idle: assert property (
    (r.powered && r.sense_nc && !rly_if.out_level) |=> relay_coil_out)
    else $error("normally closed relay not energized without alarm");
  a_no_coil_trip: assert property (
    (r.powered && !r.sense_nc && rly_if.out_level) |=> relay_coil_out)
    else $error("normally open relay not energized during trip");
  a_status_sticky: assert property (
    (r.status[EV_OL_BIT] && !(done && avs_read_in && avs_address_in == REG_STATUS))
    |=> r.status[EV_OL_BIT])
    else $error("overload event lost before status read");
  a_status_event: assert property ($rose(overload_warning_out) |-> r.status[EV_OL_BIT])
    else $error("overload rise not recorded");
  a_bus_one_wait: assert property (
    ((avs_read_in || avs_write_in) && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("access not answered after one wait cycle");
  a_wait_one_cycle: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_waitreq_idle: assert property (
    (!(avs_read_in || avs_write_in) && avs_waitrequest_out) |=> avs_waitrequest_out)
    else $error("waitrequest dropped without a request");
  a_ol_thr_default: assert property ($rose(rst_b_in) |-> r.ol_thr == OL_THR_RST)
    else $error("overload threshold not at its reset value");
  a_dev_thr_default: assert property ($rose(rst_b_in) |-> r.dev_thr == DEV_THR_RST)
    else $error("deviation threshold not at its reset value");
  a_sense_default: assert property ($rose(rst_b_in) |-> r.sense_nc == SENSE_NC_RST)
    else $error("relay sense not normally closed after reset");
endmodule
`default_nettype wire

// ==== tb/dsof_load_model.sv ====
// External loads of the status flags: a pull-up load on the transistor
// terminal and an alarm loop through the changeover relay contacts.
// Assumes the terminal is open collector and the coil input is registered.
`default_nettype none
module dsof_load_model (
  input wire logic term11_n_in,
  input wire logic relay_coil_in,
  output logic terminal_level_out,
  output logic load_on_out,
  output logic alarm_loop_closed_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Terminal load
  // ************************************************************
  // The pull-up holds the line high whenever the transistor is off
  assign terminal_level_out = (term11_n_in === 1'b0) ? 1'b0 : 1'b1;
  assign load_on_out = ~terminal_level_out;
  // ************************************************************
  // Relay alarm loop
  // ************************************************************
  // Closed loop means no alarm, so a dead coil also reads as alarm
  assign alarm_loop_closed_out = (relay_coil_in === 1'b1);
endmodule
`default_nettype wire

// ==== tb/dsof_status_flags_tb_top.sv ====
// Self-checking bench for the drive status output flags.
// Assumes the design package is compiled first; one clock, no random stimulus.
`default_nettype none
module dsof_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsof_pkg::*;
  // Short tick keeps start-up and alarm delays within a few thousand cycles
  localparam int unsigned TC = 2;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] cur;
    logic [7:0] sp;
    logic [7:0] fb;
    logic ol;
    logic od;
    logic term_n;
  } dsof_row_s;
  logic clock_in, rst_b_in, read, write, waitreq, fault;
  logic ol, od, al, term_n, coil, irq, level, load_on, loop_closed;
  logic [7:0] address, cur, sp, fb;
  logic [31:0] writedata, rdata, q;
  logic [3:0] byteenable;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  dsof_row_s rows [8] = '{
    '{8'h03, 8'h65, 8'h32, 8'h32, 1'b1, 1'b0, 1'b0},
    '{8'h03, 8'h63, 8'h32, 8'h32, 1'b0, 1'b0, 1'b1},
    '{8'h03, 8'h64, 8'h32, 8'h32, 1'b0, 1'b0, 1'b1},
    '{8'h04, 8'h64, 8'h36, 8'h32, 1'b0, 1'b1, 1'b0},
    '{8'h04, 8'h64, 8'h32, 8'h36, 1'b0, 1'b1, 1'b0},
    '{8'h04, 8'h64, 8'h32, 8'h34, 1'b0, 1'b0, 1'b1},
    '{8'h04, 8'h64, 8'h35, 8'h32, 1'b0, 1'b0, 1'b1},
    '{8'h05, 8'h65, 8'h32, 8'h32, 1'b1, 1'b0, 1'b1}
  };
  // ************************************************************
  // Design and loads
  // ************************************************************
  dsof_status_flags #(.TICK_CYCLES(TC)) DUT (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .avs_address_in(address),
    .avs_read_in(read), .avs_write_in(write), .avs_writedata_in(writedata),
    .avs_byteenable_in(byteenable), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .current_pct_in(cur), .setpoint_pct_in(sp),
    .feedback_pct_in(fb), .fault_trip_in(fault), .overload_warning_out(ol),
    .loop_deviation_out(od), .trip_alarm_out(al), .term11_n_out(term_n),
    .relay_coil_out(coil), .irq_out(irq)
  );
  dsof_load_model loads (
    .term11_n_in(term_n), .relay_coil_in(coil), .terminal_level_out(level),
    .load_on_out(load_on), .alarm_loop_closed_out(loop_closed)
  );
  // ************************************************************
  // Clock, timeout and shared tasks
  // ************************************************************
  initial clock_in = 1'b0;
  always #4 clock_in = ~clock_in;
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then lets an edge pass;
  // a slave that never answers is caught by the bench timeout
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    read <= ~wr;
    write <= wr;
    @(posedge clock_in);
    while (waitreq !== 1'b0) begin
      @(posedge clock_in);
    end
    r = rdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst_b_in = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
    cur = 8'h32;
    sp = 8'h32;
    fb = 8'h32;
    fault = 1'b0;
    cyc(2);
    rst_b_in <= 1'b1;
    cyc(1);
    check("coil_early", coil, 1'b0);
    check("term_idle", level, 1'b1);
    cyc(2945);
    check("coil_before", coil, 1'b0);
    cyc(100);
    check("loop_after", loop_closed, 1'b1);
    bus(1'b0, REG_CTRL, 32'h0000_0000, q);
    check("ctrl_rst", q, 32'h0001_0505);
    bus(1'b0, REG_OL_THR, 32'h0000_0000, q);
    check("ol_thr_rst", q, 32'h0000_0064);
    bus(1'b0, REG_DEV_THR, 32'h0000_0000, q);
    check("dev_thr_rst", q, 32'h0000_0003);
    bus(1'b0, 8'h20, 32'h0000_0000, q);
    check("unmapped", q, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(REG_CTRL, {15'h0000, 1'b1, 8'h05, rows[i].code});
      cur <= rows[i].cur;
      sp <= rows[i].sp;
      fb <= rows[i].fb;
      cyc(4);
      check("ol", ol, rows[i].ol);
      check("od", od, rows[i].od);
      check("term", level, rows[i].term_n);
    end
    wr(REG_CTRL, 32'h0001_0503);
    wr(REG_OL_THR, 32'h0000_0032);
    cur <= 8'h3C;
    cyc(4);
    check("ol_new_thr", ol, 1'b1);
    wr(REG_OL_THR, 32'h0000_0064);
    cur <= 8'h32;
    cyc(4);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    wr(REG_MASK, 32'h0000_0001);
    cur <= 8'h65;
    cyc(4);
    check("irq_set", irq, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    check("status", q, 32'h0000_0001);
    cyc(2);
    check("irq_clr", irq, 1'b0);
    wr(REG_MASK, 32'h0000_0000);
    cur <= 8'h32;
    cyc(2);
    cur <= 8'h65;
    cyc(4);
    check("irq_masked", irq, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    check("status_m", q, 32'h0000_0001);
    // One 0.1 s step of on and off delay is 100 ticks
    wr(REG_T11_DLY, 32'h0001_0001);
    cur <= 8'h32;
    cyc(300);
    cur <= 8'h65;
    cyc(150);
    check("on_dly_hold", level, 1'b1);
    cyc(110);
    check("on_dly_done", level, 1'b0);
    cur <= 8'h32;
    cyc(150);
    check("off_dly_hold", level, 1'b0);
    cyc(110);
    check("off_dly_done", level, 1'b1);
    wr(REG_T11_DLY, 32'h0000_0000);
    wr(REG_CTRL, 32'h0001_0505);
    fault <= 1'b1;
    cyc(590);
    check("al_wait", al, 1'b0);
    cyc(20);
    check("al_on", al, 1'b1);
    cyc(3);
    check("loop_trip", loop_closed, 1'b0);
    check("term_al", load_on, 1'b1);
    fault <= 1'b0;
    cyc(300);
    check("al_held", al, 1'b1);
    cyc(320);
    check("al_off", al, 1'b0);
    cyc(3);
    check("coil_back", coil, 1'b1);
    wr(REG_CTRL, 32'h0000_0505);
    cyc(3);
    check("no_idle", coil, 1'b0);
    fault <= 1'b1;
    cyc(615);
    check("no_trip", coil, 1'b1);
    fault <= 1'b0;
    cyc(615);
    check("no_clear", coil, 1'b0);
    // Reset with the relay energized so that the power loss visibly drops it
    fault <= 1'b1;
    cyc(615);
    check("coil_pre_loss", coil, 1'b1);
    rst_b_in <= 1'b0;
    cyc(2);
    check("coil_pwr_loss", coil, 1'b0);
    rst_b_in <= 1'b1;
    fault <= 1'b0;
    cyc(1);
    bus(1'b0, REG_CTRL, 32'h0000_0000, q);
    check("ctrl_rst2", q, 32'h0001_0505);
    cyc(2900);
    check("coil_restart", coil, 1'b0);
    cyc(200);
    check("coil_restart_on", coil, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
